// [alc_pkg.sv]
// alc_pkg.sv: constants and types of the input level control block
// assumes: 8-bit register port, one strobe per sample period (fs)
package alc_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] ADDR_TIMER   = 8'h06;
  localparam logic [7:0] ADDR_MODE_A  = 8'h07;
  localparam logic [7:0] ADDR_REF     = 8'h08;
  localparam logic [7:0] ADDR_GAIN    = 8'h09;
  localparam logic [7:0] ADDR_VOL     = 8'h0a;
  localparam logic [7:0] RST_TIMER    = 8'h00;
  localparam logic [7:0] RST_MODE_A   = 8'h40;
  localparam logic [6:0] RST_REF      = 7'h36;
  localparam logic [6:0] RST_GAIN     = 7'h10;
  localparam logic [7:0] RST_VOL      = 8'h18;
  localparam logic [6:0] GAIN_MAX     = 7'h47;

  // ****************************************
  // field positions
  // ****************************************
  // level_control_mode_a
  localparam int POS_THR_SEL    = 0;
  localparam int POS_RSTEP      = 1;
  localparam int POS_LATT       = 2;
  localparam int POS_ZCDIS      = 4;
  localparam int POS_IN_EN      = 5;
  localparam int POS_SPK_EN     = 6;
  // timer select
  localparam int POS_LIM_PERIOD = 0;
  localparam int POS_REC_WAIT   = 2;
  localparam int POS_ZC_TIMEOUT = 4;
  localparam int POS_SPK_PERIOD = 6;
  localparam int POS_RAMP_TIME  = 7;

  // ****************************************
  // level thresholds on 16-bit magnitude
  // ****************************************
  localparam logic [15:0] THR_M4DB = 16'h50c3;  // -4.0 dBFS
  localparam logic [15:0] THR_M6DB = 16'h4027;  // -6.0 dBFS
  localparam logic [15:0] THR_M8DB = 16'h32f5;  // -8.0 dBFS

  // ****************************************
  // periods in sample periods
  // ****************************************
  localparam logic [10:0] ZC_BASE_FS   = 11'h080;  // 128/fs
  localparam logic [10:0] WAIT_BASE_FS = 11'h080;  // 128/fs
  localparam logic [10:0] SPK_BASE_FS  = 11'h200;  // 512/fs
  localparam logic [10:0] RAMP_SLOW_FS = 11'h425;  // 1061/fs
  localparam logic [10:0] RAMP_FAST_FS = 11'h100;  // 256/fs
  localparam logic [10:0] RAMP_CODES   = 11'h0ff;  // 00h..ffh
  localparam logic [2:0]  LIM_BASE_FS  = 3'h1;

  // source of a gain change waiting for its moment
  typedef enum logic [1:0] {PEND_NONE, PEND_HOST, PEND_RECOVER, PEND_LIMIT} alc_pend_t;

endpackage

// [alc_zc_if.sv]
// alc_zc_if.sv: link between level control and its zero-cross gate
// assumes: both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface alc_zc_if;
  logic       strobe;
  logic       sign;
  logic       clear;
  logic       restart;
  logic [1:0] sel;
  logic       hit;
  modport ctrl (output strobe, sign, clear, restart, sel, input hit);
  modport gate (input strobe, sign, clear, restart, sel, output hit);
endinterface
`default_nettype wire

// [alc_zc_gate.sv]
// alc_zc_gate.sv: zero crossing / timeout moment for gain updates
// assumes: strobe is one cycle per sample, sign is the sample msb
`timescale 1ns/1ps
`default_nettype none
module alc_zc_gate (
  input  wire logic clk,
  input  wire logic rst_n,
  alc_zc_if.gate    zc
);

  logic [10:0] cnt;
  logic        last_sign;
  logic        seen;

  // ****************************************
  // crossing and timeout detect
  // ****************************************
  wire [10:0] limit    = 11'(alc_pkg::ZC_BASE_FS << zc.sel) - 11'h001;
  wire        crossing = zc.strobe && seen && (zc.sign != last_sign);
  wire        expire   = zc.strobe && (cnt == limit);

  // counter restarts on host write and on every hit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 11'h000;
      last_sign <= 1'b0;
      seen      <= 1'b0;
      zc.hit    <= 1'b0;
    end else if (zc.clear) begin
      cnt       <= 11'h000;
      seen      <= 1'b0;
      zc.hit    <= 1'b0;
    end else begin
      zc.hit <= !zc.restart && (crossing || expire);
      if (zc.restart || crossing || expire) begin
        cnt <= 11'h000;
      end else if (zc.strobe) begin
        cnt <= cnt + 11'h001;
      end
      if (zc.strobe) begin
        last_sign <= zc.sign;
        seen      <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_ZC_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    cnt <= limit || $changed(zc.sel))
    else $error("zero-cross counter passed its timeout");

endmodule
`default_nettype wire

// [alc_level_ctrl.sv]
// alc_level_ctrl.sv: input gain level control, speaker-path enable
// and output volume ramp of a mono codec
// assumes: FS_STROBE and SAMPLE_DATA on REF_CLK, power bits on REF_CLK,
// POWER_DOWN_N from a pin
//
// Operation
// - timeout field picks 128, 256, 512 or 1024 sample periods; 00 at reset.
// - host, recovery and zero-cross limiter changes wait for crossing or timeout.
// - speaker period bit picks 512 or 1024 sample periods.
// - volume ramps full range in 1061 or 256 sample periods.
// - threshold bit picks -6 or -4 dBFS; band 2 dB below resets waiting.
// - recovery raises gain one step, or two when step bit set.
// - recovery never raises gain above the reference code.
// - limiter lowers gain by one to four steps from its field.
// - limiter attenuation clamps gain code at 00.
// - zero-cross disable bit set applies limiter changes at once.
// - limiter changes use the same zero-cross timeout as recovery.
// - automatic limit and recovery run only while input enable is set.
// - speaker control active after init cycle restarted by power rising edges.
// - reference code 00 to 7f, written unclipped, reset 36h.
// - gain code 00 to 47 on host writes, up to the reference code on recovery, reset 10h, 00 to 47 in manual mode.
// - gain held at reset value while mic power is off.
// - disabling automatic control keeps the last gain reached.
// - host gain write restarts zero-cross counter; applies at crossing/timeout.
// - volume code 00 is +12 dB down in half dB, ffh mute, soft ramp.
// - immediate limiter changes repeat no faster than its period field.
// - recovery after 128 to 1024 sample periods without samples at or above the band floor.
`timescale 1ns/1ps
`default_nettype none
module alc_level_ctrl (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        POWER_DOWN_N,
  input  wire logic        MIC_POWER_EN,
  input  wire logic        SPEAKER_POWER_EN,
  input  wire logic        FS_STROBE,
  input  wire logic [15:0] SAMPLE_DATA,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic      [6:0]  GAIN_CODE,
  output logic      [7:0]  VOLUME_CODE,
  output logic             SPK_CTRL_ACTIVE
);

  // ****************************************
  // reset release and pin sampling
  // ****************************************
  logic [1:0] rst_pipe;
  logic       rst;
  logic [2:0] pin_sync;
  logic       pin_ok;

  assign rst = rst_pipe[1];

  // two-stage release of the async reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  // power-down pin: three stages, taken when last two agree
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      pin_sync <= 3'h0;
      pin_ok   <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], POWER_DOWN_N};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_ok <= pin_sync[2];
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] timer_reg;
  logic [7:0] mode_reg;
  logic [6:0] ref_code;
  logic [7:0] vol_reg;
  logic [6:0] gain;

  // write decode
  wire wr_timer = REG_WR && (REG_ADDR == alc_pkg::ADDR_TIMER);
  wire wr_mode  = REG_WR && (REG_ADDR == alc_pkg::ADDR_MODE_A);
  wire wr_ref   = REG_WR && (REG_ADDR == alc_pkg::ADDR_REF);
  wire wr_gain  = REG_WR && (REG_ADDR == alc_pkg::ADDR_GAIN);
  wire wr_vol   = REG_WR && (REG_ADDR == alc_pkg::ADDR_VOL);

  // field decode
  wire       limit_threshold_sel    = mode_reg[alc_pkg::POS_THR_SEL];
  wire       rstep                  = mode_reg[alc_pkg::POS_RSTEP];
  wire [1:0] latt                   = mode_reg[alc_pkg::POS_LATT +: 2];
  wire       zcdis                  = mode_reg[alc_pkg::POS_ZCDIS];
  wire       in_en                  = mode_reg[alc_pkg::POS_IN_EN];
  wire       spk_en                 = mode_reg[alc_pkg::POS_SPK_EN];
  wire [1:0] limit_period_sel       = timer_reg[alc_pkg::POS_LIM_PERIOD +: 2];
  wire [1:0] recovery_wait_sel      = timer_reg[alc_pkg::POS_REC_WAIT +: 2];
  wire [1:0] zero_cross_timeout_sel = timer_reg[alc_pkg::POS_ZC_TIMEOUT +: 2];
  wire       spk_level_period_sel   = timer_reg[alc_pkg::POS_SPK_PERIOD];
  wire       volume_ramp_time_sel   = timer_reg[alc_pkg::POS_RAMP_TIME];

  // manual gain is clipped into the legal code range
  wire [6:0] host_code = (REG_WDATA[6:0] > alc_pkg::GAIN_MAX) ?
                         alc_pkg::GAIN_MAX : REG_WDATA[6:0];

  // register writes; bit 7 of mode reads zero
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      timer_reg <= alc_pkg::RST_TIMER;
      mode_reg  <= alc_pkg::RST_MODE_A;
      ref_code  <= alc_pkg::RST_REF;
      vol_reg   <= alc_pkg::RST_VOL;
    end else begin
      if (wr_timer) timer_reg <= REG_WDATA;
      if (wr_mode) mode_reg <= {1'b0, REG_WDATA[6:0]};
      if (wr_ref) ref_code <= REG_WDATA[6:0];
      if (wr_vol) vol_reg <= REG_WDATA;
    end
  end

  // read mux; gain reads its live value
  wire [7:0] rd_mux = (REG_ADDR == alc_pkg::ADDR_TIMER)  ? timer_reg :
                      (REG_ADDR == alc_pkg::ADDR_MODE_A) ? mode_reg :
                      (REG_ADDR == alc_pkg::ADDR_REF)    ? {1'b0, ref_code} :
                      (REG_ADDR == alc_pkg::ADDR_GAIN)   ? {1'b0, gain} :
                      (REG_ADDR == alc_pkg::ADDR_VOL)    ? vol_reg : 8'h00;

  // registered read data
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rd_mux;
    end
  end

  // ****************************************
  // level detect
  // ****************************************
  wire        active = pin_ok && MIC_POWER_EN;
  wire        alc_on = active && in_en;
  wire [15:0] mag    = SAMPLE_DATA[15] ? 16'(~SAMPLE_DATA + 16'h0001) : SAMPLE_DATA;
  wire [15:0] thr_hi = limit_threshold_sel ? alc_pkg::THR_M4DB : alc_pkg::THR_M6DB;
  wire [15:0] thr_lo = limit_threshold_sel ? alc_pkg::THR_M6DB : alc_pkg::THR_M8DB;
  wire        over   = mag >= thr_hi;
  wire        band   = !over && (mag >= thr_lo);

  // ****************************************
  // limiter and recovery steps
  // ****************************************
  logic [2:0]  lim_cnt;
  logic [10:0] wait_cnt;

  wire [6:0]  att        = 7'(latt) + 7'h01;
  wire [6:0]  lim_target = (gain > att) ? gain - att : 7'h00;
  wire [1:0]  lim_shift  = (limit_period_sel == 2'h0) ? 2'h0 : limit_period_sel - 2'h1;
  wire [2:0]  lim_period = 3'(alc_pkg::LIM_BASE_FS << lim_shift);
  wire        lim_gap_ok = lim_cnt <= 3'h1;
  wire        lim_event  = FS_STROBE && alc_on && over;
  wire        lim_now    = lim_event && zcdis && lim_gap_ok;
  wire [7:0]  rec_sum    = {1'b0, gain} + (rstep ? 8'h02 : 8'h01);
  wire [6:0]  rec_target = (rec_sum > {1'b0, ref_code}) ?
                           ref_code : rec_sum[6:0];
  wire [10:0] wait_limit = 11'(alc_pkg::WAIT_BASE_FS << recovery_wait_sel) - 11'h001;
  wire        rec_req    = FS_STROBE && alc_on && !over && !band &&
                           (wait_cnt == wait_limit);

  // spacing of immediate limiter steps
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      lim_cnt <= 3'h0;
    end else if (!active) begin
      lim_cnt <= 3'h0;
    end else if (lim_now) begin
      lim_cnt <= lim_period;
    end else if (FS_STROBE && lim_cnt != 3'h0) begin
      lim_cnt <= lim_cnt - 3'h1;
    end
  end

  // recovery waiting counter, reset by level above the band floor
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      wait_cnt <= 11'h000;
    end else if (!alc_on || (FS_STROBE && (over || band)) || rec_req) begin
      wait_cnt <= 11'h000;
    end else if (FS_STROBE) begin
      wait_cnt <= wait_cnt + 11'h001;
    end
  end

  // ****************************************
  // zero-cross gate
  // ****************************************
  alc_zc_if zc ();

  // one gate shared by host, recovery and limiter changes
  assign zc.strobe  = FS_STROBE;
  assign zc.sign    = SAMPLE_DATA[15];
  assign zc.clear   = !active;
  assign zc.restart = wr_gain && active;
  assign zc.sel     = zero_cross_timeout_sel;

  alc_zc_gate u_zc (
    .clk   (REF_CLK),
    .rst_n (rst),
    .zc    (zc)
  );

  // ****************************************
  // gain update state
  // ****************************************
  alc_pkg::alc_pend_t pend_src;
  alc_pkg::alc_pend_t next_src;
  logic [6:0]         pend_code;
  logic [6:0]         next_code;
  logic [6:0]         next_gain;

  wire apply_pend = zc.hit && (pend_src == alc_pkg::PEND_HOST || in_en);

  // priority: power, host write, limiter, then pending change
  always_comb begin
    next_gain = gain;
    next_src  = pend_src;
    next_code = pend_code;
    if (!active) begin
      next_gain = alc_pkg::RST_GAIN;
      next_src  = alc_pkg::PEND_NONE;
    end else if (wr_gain) begin
      next_code = host_code;
      next_src  = alc_pkg::PEND_HOST;
    end else if (lim_now) begin
      next_gain = lim_target;
      next_src  = alc_pkg::PEND_NONE;
    end else if (lim_event && !zcdis) begin
      next_code = lim_target;
      next_src  = alc_pkg::PEND_LIMIT;
    end else begin
      unique case (pend_src)
        alc_pkg::PEND_NONE: begin
          if (rec_req && gain < ref_code) begin
            next_code = rec_target;
            next_src  = alc_pkg::PEND_RECOVER;
          end
        end
        alc_pkg::PEND_HOST: begin
          if (zc.hit) begin
            next_gain = pend_code;
            next_src  = alc_pkg::PEND_NONE;
          end
        end
        alc_pkg::PEND_RECOVER, alc_pkg::PEND_LIMIT: begin
          if (!in_en) begin
            next_src = alc_pkg::PEND_NONE;
          end else if (zc.hit) begin
            next_gain = pend_code;
            next_src  = alc_pkg::PEND_NONE;
          end
        end
      endcase
    end
  end

  // gain state registers
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      gain      <= alc_pkg::RST_GAIN;
      pend_src  <= alc_pkg::PEND_NONE;
      pend_code <= alc_pkg::RST_GAIN;
    end else begin
      gain      <= next_gain;
      pend_src  <= next_src;
      pend_code <= next_code;
    end
  end

  assign GAIN_CODE = gain;

  // ****************************************
  // speaker-path init cycle
  // ****************************************
  logic        spk_on_q;
  logic        spk_done;
  logic [10:0] spk_cnt;

  wire        spk_on    = pin_ok && SPEAKER_POWER_EN;
  wire        spk_rise  = spk_on && !spk_on_q;
  wire [10:0] spk_limit = 11'(alc_pkg::SPK_BASE_FS << spk_level_period_sel) - 11'h001;

  // init count restarts on either power rising edge
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      spk_on_q        <= 1'b0;
      spk_done        <= 1'b0;
      spk_cnt         <= 11'h000;
      SPK_CTRL_ACTIVE <= 1'b0;
    end else begin
      spk_on_q        <= spk_on;
      SPK_CTRL_ACTIVE <= spk_on && spk_en && spk_done;
      if (!spk_on || spk_rise) begin
        spk_done <= 1'b0;
        spk_cnt  <= 11'h000;
      end else if (FS_STROBE && !spk_done) begin
        if (spk_cnt == spk_limit) begin
          spk_done <= 1'b1;
        end else begin
          spk_cnt <= spk_cnt + 11'h001;
        end
      end
    end
  end

  // ****************************************
  // output volume soft ramp
  // ****************************************
  logic [10:0] ramp_acc;

  wire [10:0] ramp_len  = volume_ramp_time_sel ? alc_pkg::RAMP_FAST_FS
                                               : alc_pkg::RAMP_SLOW_FS;
  wire [10:0] acc_sum   = ramp_acc + alc_pkg::RAMP_CODES;
  wire        vol_moves = VOLUME_CODE != vol_reg;
  wire        ramp_step = FS_STROBE && vol_moves && (acc_sum >= ramp_len);

  // 255 codes spread evenly over the ramp length
  always_ff @(posedge REF_CLK or negedge rst) begin
    if (!rst) begin
      ramp_acc    <= 11'h000;
      VOLUME_CODE <= alc_pkg::RST_VOL;
    end else begin
      if (!vol_moves) begin
        ramp_acc <= 11'h000;
      end else if (FS_STROBE) begin
        ramp_acc <= ramp_step ? acc_sum - ramp_len : acc_sum;
      end
      if (ramp_step) begin
        VOLUME_CODE <= (VOLUME_CODE < vol_reg) ? VOLUME_CODE + 8'h01
                                               : VOLUME_CODE - 8'h01;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!rst);

  AST_GAIN_RANGE: assert property (gain <= alc_pkg::GAIN_MAX)
    else $error("gain code above 47h");

  AST_PWR_HOLD: assert property (!active |=> gain == alc_pkg::RST_GAIN)
    else $error("gain not at reset value while powered down");

  AST_REC_CAP: assert property ((zc.hit && in_en && !wr_ref &&
    pend_src == alc_pkg::PEND_RECOVER && active && !wr_gain && !lim_event)
    |=> gain <= ref_code)
    else $error("recovery passed the reference");

  AST_LIM_STEP: assert property (lim_now |=> gain == $past(lim_target))
    else $error("limiter step wrong");

  AST_LIM_CLAMP: assert property ((lim_now && gain < att) |=> gain == 7'h00)
    else $error("limiter did not clamp at 00");

  AST_HOST_WAITS: assert property ((wr_gain && active) |=>
    (pend_src == alc_pkg::PEND_HOST && gain == $past(gain)))
    else $error("host gain applied without waiting");

  AST_ALC_OFF_HOLD: assert property ((active && !in_en && !wr_gain &&
    pend_src != alc_pkg::PEND_HOST) |=> (!active || gain == $past(gain)))
    else $error("gain moved with automatic control off");

  AST_ZC_ONLY: assert property ($changed(gain) |->
    $past(!active || apply_pend || lim_now))
    else $error("gain changed outside crossing or timeout");

  AST_SPK_INIT: assert property ($rose(spk_done) |->
    ($past(spk_cnt) == spk_limit && $past(FS_STROBE)))
    else $error("speaker init cycle length wrong");

  COV_LIMIT: cover property (lim_now);
  COV_RECOVER: cover property (zc.hit && pend_src == alc_pkg::PEND_RECOVER);
  COV_HOST: cover property (zc.hit && pend_src == alc_pkg::PEND_HOST);
  COV_SPK: cover property ($rose(SPK_CTRL_ACTIVE));

endmodule
`default_nettype wire

// [alc_tb.sv]
// alc_tb.sv: self-checking bench for the input level control block
// assumes: alc_pkg and alc_level_ctrl compiled first, one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        REF_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        POWER_DOWN_N = 1'b1;
  logic        MIC_POWER_EN = 1'b1;
  logic        SPEAKER_POWER_EN = 1'b0;
  logic        FS_STROBE = 1'b0;
  logic [15:0] SAMPLE_DATA = 16'h0000;
  logic        REG_WR = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [7:0]  REG_RDATA;
  logic [6:0]  GAIN_CODE;
  logic [7:0]  VOLUME_CODE;
  logic        SPK_CTRL_ACTIVE;
  int          failures = 0;
  int          check_count = 0;
  logic [7:0]  rst_addr [6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
  logic [7:0]  rst_val [6] = '{8'h00, 8'h40, 8'h36, 8'h10, 8'h18, 8'h00};

  alc_level_ctrl alc_level_ctrl_i (
    .REF_CLK         (REF_CLK),
    .RST_N           (RST_N),
    .POWER_DOWN_N    (POWER_DOWN_N),
    .MIC_POWER_EN    (MIC_POWER_EN),
    .SPEAKER_POWER_EN(SPEAKER_POWER_EN),
    .FS_STROBE       (FS_STROBE),
    .SAMPLE_DATA     (SAMPLE_DATA),
    .REG_WR          (REG_WR),
    .REG_ADDR        (REG_ADDR),
    .REG_WDATA       (REG_WDATA),
    .REG_RDATA       (REG_RDATA),
    .GAIN_CODE       (GAIN_CODE),
    .VOLUME_CODE     (VOLUME_CODE),
    .SPK_CTRL_ACTIVE (SPK_CTRL_ACTIVE)
  );

  // ****************************************
  // clock and helper tasks
  // ****************************************
  // 50 ns period
  always #25 REF_CLK = ~REF_CLK;

  // compare one 8-bit result
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge REF_CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge REF_CLK);
    REG_WR = 1'b0;
  endtask

  // registered read, data one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge REF_CLK);
    REG_ADDR = a;
    @(negedge REF_CLK);
    chk("reg", exp, REG_RDATA);
  endtask

  // n sample strobes two cycles apart, sign flipped each time if alt
  task automatic fs(input int n, input logic [15:0] d, input bit alt);
    logic [15:0] sd;
    sd = d;
    for (int i = 0; i < n; i++) begin
      @(negedge REF_CLK);
      FS_STROBE = 1'b1;
      SAMPLE_DATA = sd;
      @(negedge REF_CLK);
      FS_STROBE = 1'b0;
      if (alt) sd = -sd;
    end
  endtask

  // gain compare after the gate latency has settled
  task automatic chkg(input logic [6:0] exp);
    repeat (3) @(negedge REF_CLK);
    chk("gain", {1'b0, exp}, {1'b0, GAIN_CODE});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge REF_CLK);
    RST_N = 1'b1;
    repeat (8) @(negedge REF_CLK);
    for (int i = 0; i < 6; i++) rd(rst_addr[i], rst_val[i]);
    $display("test reset_values done");
    fs(100, 16'h0100, 0);
    wr(8'h09, 8'h20);
    fs(127, 16'h0100, 0);
    chkg(7'h10);
    fs(1, 16'h0100, 0);
    chkg(7'h20);
    wr(8'h06, 8'h10);
    wr(8'h09, 8'h30);
    fs(255, 16'h0100, 0);
    chkg(7'h20);
    fs(1, 16'h0100, 0);
    chkg(7'h30);
    wr(8'h09, 8'h47);
    fs(2, 16'h0100, 1);
    chkg(7'h47);
    $display("test host_gain done");
    wr(8'h07, 8'h7c);
    fs(1, 16'h7000, 0);
    chkg(7'h43);
    fs(1, 16'h7000, 0);
    chkg(7'h3f);
    wr(8'h07, 8'h40);
    fs(3, 16'h0100, 1);
    chkg(7'h3f);
    wr(8'h09, 8'h02);
    fs(2, 16'h0100, 1);
    chkg(7'h02);
    wr(8'h07, 8'h7c);
    fs(1, 16'h7000, 0);
    chkg(7'h00);
    $display("test limiter done");
    wr(8'h08, 8'h03);
    wr(8'h07, 8'h62);
    fs(140, 16'h0100, 1);
    chkg(7'h02);
    fs(140, 16'h0100, 1);
    chkg(7'h03);
    fs(140, 16'h0100, 1);
    chkg(7'h03);
    $display("test recovery done");
    wr(8'h07, 8'h7d);
    fs(1, 16'hb800, 0);
    chkg(7'h03);
    wr(8'h07, 8'h6d);
    fs(1, 16'h9000, 0);
    chkg(7'h03);
    fs(1, 16'h7000, 0);
    chkg(7'h00);
    $display("test zero_cross_limiter done");
    MIC_POWER_EN = 1'b0;
    fs(2, 16'h0100, 1);
    chkg(7'h10);
    rd(8'h09, 8'h10);
    $display("test mic_power done");
    SPEAKER_POWER_EN = 1'b1;
    wr(8'h0a, 8'h1a);
    fs(8, 16'h0100, 0);
    chk("vol", 8'h19, VOLUME_CODE);
    fs(503, 16'h0100, 0);
    chk("spk", 8'h00, {7'h00, SPK_CTRL_ACTIVE});
    chk("vol", 8'h1a, VOLUME_CODE);
    fs(1, 16'h0100, 0);
    repeat (3) @(negedge REF_CLK);
    chk("spk", 8'h01, {7'h00, SPK_CTRL_ACTIVE});
    $display("test speaker_volume done");
    report_and_stop();
  end
endmodule
`default_nettype wire
